// ===== hdl/cabe_exec.v
// The APB interface to the registers and the address map are this design's own decisions.
`include "cabe_regs.vh"

module cabe_exec (
   input  wire        mclk,
   input  wire        resetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         busy
);
   localparam ST_IDLE  = 1'b0;
   localparam ST_EXEC  = 1'b1;
   localparam FL_NONE  = 3'd0;
   localparam FL_ADD   = 3'd1;
   localparam FL_SUB   = 3'd2;
   localparam FL_LOGIC = 3'd3;
   localparam FL_SHIFT = 3'd4;
   localparam FL_WADD  = 3'd5;
   localparam FL_WSUB  = 3'd6;

   reg        state;
   reg        first;
   reg [1:0]  rem;
   reg [5:0]  op;
   reg [15:0] opa;
   reg [7:0]  opb;
   reg [15:0] sel;
   reg [15:0] ofs;
   reg [15:0] pc;
   reg [7:0]  status_flags_reg;
   reg [15:0] zptr;
   reg [15:0] ret_addr;
   reg [1:0]  last_cyc;
   reg        last_skip;

   reg [31:0] rd_val;
   reg        rd_ok;
   reg        wr_able;

   reg        cin;
   reg        bin;
   reg [8:0]  sum9;
   reg [8:0]  dif9;
   reg [16:0] wsum;
   reg [16:0] wdif;
   reg [15:0] tgt;
   reg [7:0]  a;
   reg [7:0]  b;
   reg [7:0]  res;
   reg [15:0] wres;
   reg        cout;
   reg [2:0]  cls;
   reg        st8;
   reg        st16;
   reg        do_ret;
   reg        is_br;
   reg        taken;
   reg        skip;
   reg        io_we;
   reg [7:0]  io_bits;
   reg [7:0]  n_status_flags_reg;
   reg [15:0] n_pc;
   reg [1:0]  n_cyc;

   wire [2:0] bit_sel  = sel[`CABE_SEL_BIT_LSB +: 3];
   wire [4:0] io_addr  = sel[`CABE_SEL_IO_LSB +: 5];
   wire       two_word = sel[`CABE_SEL_TWO_WORD];
   wire [7:0] io_rdata;

   wire setup   = psel & ~penable;
   wire wr_acc  = psel & penable & pready & pwrite & ~pslverr;
   wire commit  = (state == ST_EXEC) & first;
   wire io_host = wr_acc & (paddr == `CABE_ADDR_IODATA);

   wire       mem_we    = (commit & io_we) | io_host;
   wire [7:0] mem_wdata = io_host ? pwdata[7:0] : io_bits;
   wire [7:0] bit_mask  = 8'h01 << bit_sel;
   wire [7:0] mem_mask  = io_host ? `CABE_BYTE_ALL : bit_mask;

   // only 5 address bits exist, so io bit access cannot leave 0x00-0x1F
   cabe_io_mem u_io_mem (
      .mclk    (mclk),
      .resetn  (resetn),
      .wr_en   (mem_we),
      .addr    (io_addr),
      .wr_data (mem_wdata),
      .wr_mask (mem_mask),
      .rd_data (io_rdata)
   );

   always @* begin
      rd_val  = 32'h0000_0000;
      rd_ok   = 1'b1;
      wr_able = 1'b1;
      if (paddr == `CABE_ADDR_CMD) begin
         rd_val[5:0] = op;
      end else if (paddr == `CABE_ADDR_OPA) begin
         rd_val[15:0] = opa;
      end else if (paddr == `CABE_ADDR_OPB) begin
         rd_val[7:0] = opb;
      end else if (paddr == `CABE_ADDR_SEL) begin
         rd_val[15:0] = sel;
      end else if (paddr == `CABE_ADDR_OFS) begin
         rd_val[15:0] = ofs;
      end else if (paddr == `CABE_ADDR_PC) begin
         rd_val[15:0] = pc;
      end else if (paddr == `CABE_ADDR_STATUS_FLAGS_REG) begin
         rd_val[7:0] = status_flags_reg;
      end else if (paddr == `CABE_ADDR_ZPTR) begin
         rd_val[15:0] = zptr;
      end else if (paddr == `CABE_ADDR_RET) begin
         rd_val[15:0] = ret_addr;
         wr_able      = 1'b0;
      end else if (paddr == `CABE_ADDR_STAT) begin
         rd_val[`CABE_STAT_BUSY]         = state;
         rd_val[`CABE_STAT_SKIP]         = last_skip;
         rd_val[`CABE_STAT_CYC_LSB +: 2] = last_cyc;
         wr_able                         = 1'b0;
      end else if (paddr == `CABE_ADDR_IODATA) begin
         rd_val[7:0] = io_rdata;
      end else begin
         rd_ok   = 1'b0;
         wr_able = 1'b0;
      end
   end

   always @* begin
      a      = opa[7:0];
      b      = opb;
      cin    = (op == `CABE_OP_SUM_CARRY) & status_flags_reg[`CABE_FL_C];
      bin    = ((op == `CABE_OP_DIFF_BORROW) | (op == `CABE_OP_DIFF_IMM_BORROW))
               & status_flags_reg[`CABE_FL_C];
      sum9   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      dif9   = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      wsum   = {1'b0, opa} + {11'h000, opb[5:0]};
      wdif   = {1'b0, opa} - {11'h000, opb[5:0]};
      tgt    = pc + ofs + 16'h0001;
      res    = a;
      wres   = opa;
      cout   = 1'b0;
      cls    = FL_NONE;
      st8    = 1'b0;
      st16   = 1'b0;
      do_ret = 1'b0;
      is_br  = 1'b0;
      taken  = 1'b0;
      skip   = 1'b0;
      io_we  = 1'b0;
      io_bits = 8'h00;
      n_pc   = pc + 16'h0001;
      n_cyc  = `CABE_CYC_ONE;
      case (op)
         `CABE_OP_SUM_REGS, `CABE_OP_SUM_CARRY: begin
            res = sum9[7:0];
            st8 = 1'b1;
            cls = FL_ADD;
         end
         `CABE_OP_WORD_SUM_IMM: begin
            wres  = wsum[15:0];
            st16  = 1'b1;
            cls   = FL_WADD;
            n_cyc = `CABE_CYC_TWO;
         end
         `CABE_OP_WORD_DIFF_IMM: begin
            wres  = wdif[15:0];
            st16  = 1'b1;
            cls   = FL_WSUB;
            n_cyc = `CABE_CYC_TWO;
         end
         `CABE_OP_DIFF_REGS, `CABE_OP_DIFF_IMM,
         `CABE_OP_DIFF_BORROW, `CABE_OP_DIFF_IMM_BORROW: begin
            res = dif9[7:0];
            st8 = 1'b1;
            cls = FL_SUB;
         end
         `CABE_OP_CMP_IMM: begin
            res = dif9[7:0];
            cls = FL_SUB;
         end
         `CABE_OP_BOTH_REGS, `CABE_OP_BOTH_IMM: begin
            res = a & b;
            st8 = 1'b1;
            cls = FL_LOGIC;
         end
         `CABE_OP_EITHER_REGS, `CABE_OP_EITHER_IMM, `CABE_OP_MASK_SET: begin
            res = a | b;
            st8 = 1'b1;
            cls = FL_LOGIC;
         end
         `CABE_OP_XOR_REGS: begin
            res = a ^ b;
            st8 = 1'b1;
            cls = FL_LOGIC;
         end
         `CABE_OP_MASK_CLEAR: begin
            res = a & (`CABE_BYTE_ALL - b);
            st8 = 1'b1;
            cls = FL_LOGIC;
         end
         `CABE_OP_ZERO_SIGN_TEST: begin
            res = a & a;
            cls = FL_LOGIC;
         end
         `CABE_OP_REL_JUMP: begin
            n_pc  = tgt;
            n_cyc = `CABE_CYC_TWO;
         end
         `CABE_OP_REL_CALL: begin
            n_pc   = tgt;
            do_ret = 1'b1;
            n_cyc  = `CABE_CYC_THREE;
         end
         `CABE_OP_PTR_JUMP: begin
            n_pc  = zptr;
            n_cyc = `CABE_CYC_TWO;
         end
         `CABE_OP_PTR_CALL: begin
            n_pc   = zptr;
            do_ret = 1'b1;
            n_cyc  = `CABE_CYC_THREE;
         end
         `CABE_OP_EQ_CMP_SKIP:   skip = (a == b);
         `CABE_OP_SKIP_REG_LOW:  skip = ~a[bit_sel];
         `CABE_OP_SKIP_REG_HIGH: skip = a[bit_sel];
         `CABE_OP_SKIP_IO_LOW:   skip = ~io_rdata[bit_sel];
         `CABE_OP_SKIP_IO_HIGH:  skip = io_rdata[bit_sel];
         `CABE_OP_BR_FLAG_HIGH: begin
            is_br = 1'b1;
            taken = status_flags_reg[bit_sel];
         end
         `CABE_OP_BR_FLAG_LOW: begin
            is_br = 1'b1;
            taken = ~status_flags_reg[bit_sel];
         end
         `CABE_OP_BR_SIGNED_GE: begin
            is_br = 1'b1;
            taken = ~(status_flags_reg[`CABE_FL_N] ^ status_flags_reg[`CABE_FL_V]);
         end
         `CABE_OP_BR_SIGNED_LESS: begin
            is_br = 1'b1;
            taken = status_flags_reg[`CABE_FL_N] ^ status_flags_reg[`CABE_FL_V];
         end
         `CABE_OP_BR_UNSIGNED_GE: begin
            is_br = 1'b1;
            taken = ~status_flags_reg[`CABE_FL_C];
         end
         `CABE_OP_BR_UNSIGNED_LESS: begin
            is_br = 1'b1;
            taken = status_flags_reg[`CABE_FL_C];
         end
         `CABE_OP_BR_IRQ_ON: begin
            is_br = 1'b1;
            taken = status_flags_reg[`CABE_FL_I];
         end
         `CABE_OP_BR_IRQ_OFF: begin
            is_br = 1'b1;
            taken = ~status_flags_reg[`CABE_FL_I];
         end
         `CABE_OP_BR_HALF_HIGH: begin
            is_br = 1'b1;
            taken = status_flags_reg[`CABE_FL_H];
         end
         `CABE_OP_BR_HALF_LOW: begin
            is_br = 1'b1;
            taken = ~status_flags_reg[`CABE_FL_H];
         end
         `CABE_OP_BR_T_HIGH: begin
            is_br = 1'b1;
            taken = status_flags_reg[`CABE_FL_T];
         end
         `CABE_OP_BR_T_LOW: begin
            is_br = 1'b1;
            taken = ~status_flags_reg[`CABE_FL_T];
         end
         `CABE_OP_BR_OVF_HIGH: begin
            is_br = 1'b1;
            taken = status_flags_reg[`CABE_FL_V];
         end
         `CABE_OP_BR_OVF_LOW: begin
            is_br = 1'b1;
            taken = ~status_flags_reg[`CABE_FL_V];
         end
         `CABE_OP_IO_BIT_SET, `CABE_OP_IO_BIT_CLEAR: begin
            io_we   = 1'b1;
            io_bits = (op == `CABE_OP_IO_BIT_SET) ? `CABE_BYTE_ALL : 8'h00;
            n_cyc   = `CABE_CYC_TWO;
         end
         `CABE_OP_ROT_LEFT: begin
            res  = {a[6:0], status_flags_reg[`CABE_FL_C]};
            cout = a[7];
            st8  = 1'b1;
            cls  = FL_SHIFT;
         end
         `CABE_OP_ROT_RIGHT: begin
            res  = {status_flags_reg[`CABE_FL_C], a[7:1]};
            cout = a[0];
            st8  = 1'b1;
            cls  = FL_SHIFT;
         end
         `CABE_OP_SHIFT_LEFT: begin
            res  = {a[6:0], 1'b0};
            cout = a[7];
            st8  = 1'b1;
            cls  = FL_SHIFT;
         end
         `CABE_OP_SHIFT_RIGHT: begin
            res  = {1'b0, a[7:1]};
            cout = a[0];
            st8  = 1'b1;
            cls  = FL_SHIFT;
         end
         default: begin
            cls = FL_NONE;
         end
      endcase
      if (is_br & taken) begin
         n_pc  = tgt;
         n_cyc = `CABE_CYC_TWO;
      end
      // the length of the skipped word is software's to tell, via sel
      if (skip) begin
         n_pc  = pc + (two_word ? 16'h0003 : 16'h0002);
         n_cyc = two_word ? `CABE_CYC_THREE : `CABE_CYC_TWO;
      end
      n_status_flags_reg = status_flags_reg;
      case (cls)
         FL_ADD: begin
            n_status_flags_reg[`CABE_FL_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            n_status_flags_reg[`CABE_FL_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
            n_status_flags_reg[`CABE_FL_C] = sum9[8];
         end
         FL_SUB: begin
            n_status_flags_reg[`CABE_FL_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            n_status_flags_reg[`CABE_FL_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
            n_status_flags_reg[`CABE_FL_C] = dif9[8];
         end
         FL_LOGIC: begin
            n_status_flags_reg[`CABE_FL_V] = 1'b0;
         end
         FL_SHIFT: begin
            n_status_flags_reg[`CABE_FL_C] = cout;
            n_status_flags_reg[`CABE_FL_V] = res[7] ^ cout;
         end
         FL_WADD: begin
            n_status_flags_reg[`CABE_FL_V] = ~opa[15] & wres[15];
            n_status_flags_reg[`CABE_FL_C] = ~wres[15] & opa[15];
         end
         FL_WSUB: begin
            n_status_flags_reg[`CABE_FL_V] = opa[15] & ~wres[15];
            n_status_flags_reg[`CABE_FL_C] = wres[15] & ~opa[15];
         end
         default: begin
            n_status_flags_reg = status_flags_reg;
         end
      endcase
      if ((cls == FL_WADD) | (cls == FL_WSUB)) begin
         n_status_flags_reg[`CABE_FL_N] = wres[15];
         n_status_flags_reg[`CABE_FL_Z] = (wres == 16'h0000);
         n_status_flags_reg[`CABE_FL_S] = wres[15] ^ n_status_flags_reg[`CABE_FL_V];
      end else if (cls != FL_NONE) begin
         n_status_flags_reg[`CABE_FL_N] = res[7];
         n_status_flags_reg[`CABE_FL_Z] = (res == 8'h00);
      end
   end

   // APB answers with zero wait states; the reply is prepared in setup
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & (~rd_ok | (pwrite & (~wr_able | state)));
         if (setup & ~pwrite) begin
            prdata <= rd_ok ? rd_val : 32'h0000_0000;
         end
      end
   end

   // every operand and result register except the io memory (cabe_io_mem) lives here; software writes are
   // refused while busy, so they never collide with a commit
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state     <= ST_IDLE;
         busy      <= 1'b0;
         first     <= 1'b0;
         rem       <= 2'd0;
         op        <= 6'h00;
         opa       <= `CABE_RST_16;
         opb       <= `CABE_RST_8;
         sel       <= `CABE_RST_16;
         ofs       <= `CABE_RST_16;
         pc        <= `CABE_RST_16;
         status_flags_reg      <= `CABE_RST_8;
         zptr      <= `CABE_RST_16;
         ret_addr  <= `CABE_RST_16;
         last_cyc  <= 2'd0;
         last_skip <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wr_acc) begin
                  if (paddr == `CABE_ADDR_CMD) begin
                     op    <= pwdata[5:0];
                     state <= ST_EXEC;
                     busy  <= 1'b1;
                     first <= 1'b1;
                  end else if (paddr == `CABE_ADDR_OPA) begin
                     opa <= pwdata[15:0];
                  end else if (paddr == `CABE_ADDR_OPB) begin
                     opb <= pwdata[7:0];
                  end else if (paddr == `CABE_ADDR_SEL) begin
                     sel <= pwdata[15:0];
                  end else if (paddr == `CABE_ADDR_OFS) begin
                     ofs <= pwdata[15:0];
                  end else if (paddr == `CABE_ADDR_PC) begin
                     pc <= pwdata[15:0];
                  end else if (paddr == `CABE_ADDR_STATUS_FLAGS_REG) begin
                     status_flags_reg <= pwdata[7:0];
                  end else if (paddr == `CABE_ADDR_ZPTR) begin
                     zptr <= pwdata[15:0];
                  end
               end
            end
            ST_EXEC: begin
               if (first) begin
                  first     <= 1'b0;
                  status_flags_reg      <= n_status_flags_reg;
                  pc        <= n_pc;
                  last_cyc  <= n_cyc;
                  last_skip <= skip;
                  rem       <= n_cyc - 2'd1;
                  if (st8) begin
                     opa[7:0] <= res;
                  end
                  if (st16) begin
                     opa <= wres;
                  end
                  if (do_ret) begin
                     ret_addr <= pc + 16'h0001;
                  end
                  if (n_cyc == `CABE_CYC_ONE) begin
                     state <= ST_IDLE;
                     busy  <= 1'b0;
                  end
               end else begin
                  rem <= rem - 2'd1;
                  if (rem == 2'd1) begin
                     state <= ST_IDLE;
                     busy  <= 1'b0;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ===== inc/cabe_regs.vh
`ifndef CABE_REGS_VH
`define CABE_REGS_VH

`define CABE_ADDR_CMD      8'h00
`define CABE_ADDR_OPA      8'h04
`define CABE_ADDR_OPB      8'h08
`define CABE_ADDR_SEL      8'h0C
`define CABE_ADDR_OFS      8'h10
`define CABE_ADDR_PC       8'h14
`define CABE_ADDR_STATUS_FLAGS_REG     8'h18
`define CABE_ADDR_ZPTR     8'h1C
`define CABE_ADDR_RET      8'h20
`define CABE_ADDR_STAT     8'h24
`define CABE_ADDR_IODATA   8'h28

`define CABE_FL_C          0
`define CABE_FL_Z          1
`define CABE_FL_N          2
`define CABE_FL_V          3
`define CABE_FL_S          4
`define CABE_FL_H          5
`define CABE_FL_T          6
`define CABE_FL_I          7

`define CABE_SEL_BIT_LSB   0
`define CABE_SEL_IO_LSB    8
`define CABE_SEL_TWO_WORD  15
`define CABE_STAT_BUSY     0
`define CABE_STAT_SKIP     1
`define CABE_STAT_CYC_LSB  4

`define CABE_RST_16        16'h0000
`define CABE_RST_8         8'h00
`define CABE_BYTE_ALL      8'hFF

`define CABE_CYC_ONE       2'd1
`define CABE_CYC_TWO       2'd2
`define CABE_CYC_THREE     2'd3

`define CABE_OP_SUM_REGS         6'h00
`define CABE_OP_SUM_CARRY        6'h01
`define CABE_OP_WORD_SUM_IMM     6'h02
`define CABE_OP_DIFF_REGS        6'h03
`define CABE_OP_DIFF_IMM         6'h04
`define CABE_OP_DIFF_BORROW      6'h05
`define CABE_OP_DIFF_IMM_BORROW  6'h06
`define CABE_OP_WORD_DIFF_IMM    6'h07
`define CABE_OP_BOTH_REGS        6'h08
`define CABE_OP_BOTH_IMM         6'h09
`define CABE_OP_EITHER_REGS      6'h0A
`define CABE_OP_EITHER_IMM       6'h0B
`define CABE_OP_XOR_REGS         6'h0C
`define CABE_OP_MASK_SET         6'h0D
`define CABE_OP_MASK_CLEAR       6'h0E
`define CABE_OP_ZERO_SIGN_TEST   6'h0F
`define CABE_OP_REL_JUMP         6'h10
`define CABE_OP_REL_CALL         6'h11
`define CABE_OP_PTR_JUMP         6'h12
`define CABE_OP_PTR_CALL         6'h13
`define CABE_OP_EQ_CMP_SKIP      6'h14
`define CABE_OP_CMP_IMM          6'h15
`define CABE_OP_SKIP_REG_LOW     6'h16
`define CABE_OP_SKIP_REG_HIGH    6'h17
`define CABE_OP_SKIP_IO_LOW      6'h18
`define CABE_OP_SKIP_IO_HIGH     6'h19
`define CABE_OP_BR_FLAG_HIGH     6'h1A
`define CABE_OP_BR_FLAG_LOW      6'h1B
`define CABE_OP_BR_SIGNED_GE     6'h1C
`define CABE_OP_BR_SIGNED_LESS   6'h1D
`define CABE_OP_BR_UNSIGNED_GE   6'h1E
`define CABE_OP_BR_UNSIGNED_LESS 6'h1F
`define CABE_OP_BR_IRQ_ON        6'h20
`define CABE_OP_BR_IRQ_OFF       6'h21
`define CABE_OP_BR_HALF_HIGH     6'h22
`define CABE_OP_BR_HALF_LOW      6'h23
`define CABE_OP_BR_T_HIGH        6'h24
`define CABE_OP_BR_T_LOW         6'h25
`define CABE_OP_BR_OVF_HIGH      6'h26
`define CABE_OP_BR_OVF_LOW       6'h27
`define CABE_OP_IO_BIT_SET       6'h28
`define CABE_OP_IO_BIT_CLEAR     6'h29
`define CABE_OP_ROT_LEFT         6'h2A
`define CABE_OP_ROT_RIGHT        6'h2B
`define CABE_OP_SHIFT_LEFT       6'h2C
`define CABE_OP_SHIFT_RIGHT      6'h2D

`endif

// ===== hdl/cabe_io_mem.v
module cabe_io_mem (
   input  wire       mclk,
   input  wire       resetn,
   input  wire       wr_en,
   input  wire [4:0] addr,
   input  wire [7:0] wr_data,
   input  wire [7:0] wr_mask,
   output reg  [7:0] rd_data
);
   reg [7:0] mem [0:31];

   // masked write: bits outside the mask keep their stored value, so a
   // write-one-to-clear flag next to the target bit is never touched
   always @(posedge mclk) begin
      if (wr_en) begin
         mem[addr] <= (mem[addr] & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   // read data lags the array by one edge
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[addr];
      end
   end
endmodule

// ===== verif/cabe_exec_assertions.sv
`include "cabe_regs.vh"

module cabe_exec_assertions (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   wire       setup = psel && !penable;
   wire       go = psel && penable && pready && pwrite && !pslverr && paddr == `CABE_ADDR_CMD;
   wire [5:0] op = pwdata[5:0];
   wire       alu = op <= `CABE_OP_ZERO_SIGN_TEST && op != `CABE_OP_WORD_SUM_IMM
                    && op != `CABE_OP_WORD_DIFF_IMM;
   chk_ready_after_setup: assert property (setup |=> pready)
      else $error("no ready after setup");
   chk_ready_has_cause: assert property (pready |-> $past(setup))
      else $error("ready without setup");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_busy_write_err: assert property (setup && pwrite && busy |=> pslverr)
      else $error("write while busy accepted");
   chk_ro_write_err: assert property (setup && pwrite
      && (paddr == `CABE_ADDR_RET || paddr == `CABE_ADDR_STAT) |=> pslverr)
      else $error("read-only write accepted");
   chk_alu_one_cycle: assert property (go && alu |=> busy ##1 !busy)
      else $error("alu op not one cycle");
   chk_word_two_cycles: assert property (go && (op == `CABE_OP_WORD_SUM_IMM
      || op == `CABE_OP_WORD_DIFF_IMM) |=> busy [*2] ##1 !busy)
      else $error("word op not two cycles");
   chk_call_three_cycles: assert property (go && (op == `CABE_OP_REL_CALL
      || op == `CABE_OP_PTR_CALL) |=> busy [*3] ##1 !busy)
      else $error("call not three cycles");
   chk_io_bit_two: assert property (go && (op == `CABE_OP_IO_BIT_SET
      || op == `CABE_OP_IO_BIT_CLEAR) |=> busy [*2] ##1 !busy)
      else $error("io bit op not two cycles");
   chk_busy_bounded: assert property ($rose(busy) |-> ##3 !busy)
      else $error("busy too long");
   cover property (go && op == `CABE_OP_REL_CALL);
   cover property (setup && pwrite && busy ##1 pslverr);
   cover property ($rose(busy) ##2 busy);
endmodule

bind cabe_exec cabe_exec_assertions cabe_exec_assertions_inst (.mclk(mclk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// ===== verif/tb_top.sv
`include "cabe_regs.vh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // row: op a b status_flags_reg sel | expected a, status_flags_reg, pc, cycles (pc starts 0x100, offset 0x10)
   typedef struct packed {
      logic [7:0]  op;
      logic [15:0] a;
      logic [7:0]  b;
      logic [7:0]  sr;
      logic [15:0] sel;
      logic [15:0] ea;
      logic [7:0]  es;
      logic [15:0] epc;
      logic [3:0]  cyc;
   } cabe_row_t;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         busy;
   logic [31:0] q;
   logic        e;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          ticks = 0;
   cabe_row_t   r;
   cabe_row_t   rows [38] = '{
      100'h00_000F_01_00_0000_0010_20_0101_1,
      100'h01_00FF_00_01_0000_0000_23_0101_1,
      100'h02_7FFF_01_00_0000_8000_0C_0101_2,
      100'h07_0000_01_00_0000_FFFF_15_0101_2,
      100'h03_0010_01_00_0000_000F_20_0101_1,
      100'h06_0000_00_01_0000_00FF_25_0101_1,
      100'h04_0080_01_00_0000_007F_28_0101_1,
      100'h09_00F0_0F_09_0000_0000_03_0101_1,
      100'h08_00F3_3C_00_0000_0030_00_0101_1,
      100'h0A_0000_00_00_0000_0000_02_0101_1,
      100'h0C_00FF_0F_08_0000_00F0_04_0101_1,
      100'h0E_00FF_0F_00_0000_00F0_04_0101_1,
      100'h0D_0001_80_00_0000_0081_04_0101_1,
      100'h0F_0080_00_00_0000_0080_04_0101_1,
      100'h15_0005_05_00_0000_0005_02_0101_1,
      100'h2A_0080_00_01_0000_0001_09_0101_1,
      100'h2B_0001_00_00_0000_0000_0B_0101_1,
      100'h2C_0081_00_00_0000_0002_09_0101_1,
      100'h2D_1201_00_00_0000_1200_0B_0101_1,
      100'h10_0000_00_00_0000_0000_00_0111_2,
      100'h11_0000_00_00_0000_0000_00_0111_3,
      100'h12_0000_00_00_0000_0000_00_0000_2,
      100'h14_0033_33_3F_0000_0033_3F_0102_2,
      100'h16_00FE_00_00_8000_00FE_00_0103_3,
      100'h17_00FE_00_00_0000_00FE_00_0101_1,
      100'h1C_0000_00_0C_0000_0000_0C_0111_2,
      100'h1D_0000_00_0C_0000_0000_0C_0101_1,
      100'h1E_0000_00_01_0000_0000_01_0101_1,
      100'h1F_0000_00_01_0000_0000_01_0111_2,
      100'h20_0000_00_80_0000_0000_80_0111_2,
      100'h21_0000_00_80_0000_0000_80_0101_1,
      100'h22_0000_00_20_0000_0000_20_0111_2,
      100'h24_0000_00_40_0000_0000_40_0111_2,
      100'h25_0000_00_40_0000_0000_40_0101_1,
      100'h27_0000_00_08_0000_0000_08_0101_1,
      100'h3F_0055_00_FF_0000_0055_FF_0101_1,
      100'h1A_0000_00_02_0001_0000_02_0111_2,
      100'h1B_0000_00_02_0001_0000_02_0101_1};

   always #20 mclk = ~mclk;

   cabe_exec cabe_exec_inst (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy));

   task automatic test_done;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // request held until pready is seen at a rising edge, released only then
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h00000000);
      chk(q, x);
   endtask

   task automatic idle;
      do bus(1'b0, `CABE_ADDR_STAT, 32'h00000000); while (q[0] !== 1'b0);
   endtask

   task automatic run(input logic [5:0] op);
      bus(1'b1, `CABE_ADDR_CMD, {26'h0000000, op});
      idle;
   endtask

   always @(posedge mclk) begin
      ticks++;
      if (ticks == 8000) begin
         n_errors++;
         test_done;
      end
   end

   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         bus(1'b1, `CABE_ADDR_PC, 32'h00000100);
         bus(1'b1, `CABE_ADDR_OFS, 32'h00000010);
         bus(1'b1, `CABE_ADDR_STATUS_FLAGS_REG, {24'h000000, r.sr});
         bus(1'b1, `CABE_ADDR_OPA, {16'h0000, r.a});
         bus(1'b1, `CABE_ADDR_OPB, {24'h000000, r.b});
         bus(1'b1, `CABE_ADDR_SEL, {16'h0000, r.sel});
         run(r.op[5:0]);
         chk({30'h00000000, q[5:4]}, {28'h0000000, r.cyc});
         rdchk(`CABE_ADDR_OPA, {16'h0000, r.ea});
         rdchk(`CABE_ADDR_STATUS_FLAGS_REG, {24'h000000, r.es});
         rdchk(`CABE_ADDR_PC, {16'h0000, r.epc});
      end
      bus(1'b1, `CABE_ADDR_PC, 32'h00000000);
      bus(1'b1, `CABE_ADDR_SEL, 32'h00001F03);
      bus(1'b1, `CABE_ADDR_IODATA, 32'h000000A5);
      run(`CABE_OP_IO_BIT_SET);
      chk({30'h00000000, q[5:4]}, 32'h00000002);
      rdchk(`CABE_ADDR_IODATA, 32'h000000AD);
      run(`CABE_OP_SKIP_IO_HIGH);
      chk({30'h00000000, q[5:4]}, 32'h00000002);
      chk({31'h00000000, q[`CABE_STAT_SKIP]}, 32'h00000001);
      rdchk(`CABE_ADDR_PC, 32'h00000003);
      run(`CABE_OP_IO_BIT_CLEAR);
      rdchk(`CABE_ADDR_IODATA, 32'h000000A5);
      run(`CABE_OP_SKIP_IO_LOW);
      rdchk(`CABE_ADDR_PC, 32'h00000006);
      bus(1'b1, `CABE_ADDR_ZPTR, 32'h00000234);
      bus(1'b1, `CABE_ADDR_PC, 32'h00000050);
      bus(1'b1, `CABE_ADDR_CMD, {26'h0000000, `CABE_OP_PTR_CALL});
      // sample busy mid-cycle, away from the edge that launched it
      @(negedge mclk);
      chk({31'h00000000, busy}, 32'h00000001);
      bus(1'b1, `CABE_ADDR_OPA, 32'h00000055);
      chk({31'h00000000, e}, 32'h00000001);
      idle;
      rdchk(`CABE_ADDR_OPA, 32'h00000000);
      rdchk(`CABE_ADDR_PC, 32'h00000234);
      rdchk(`CABE_ADDR_RET, 32'h00000051);
      bus(1'b1, `CABE_ADDR_RET, 32'h00000001);
      chk({31'h00000000, e}, 32'h00000001);
      rdchk(8'h40, 32'h00000000);
      chk({31'h00000000, e}, 32'h00000001);
      // reset lands while a call is in flight, so busy must drop too
      bus(1'b1, `CABE_ADDR_CMD, {26'h0000000, `CABE_OP_REL_CALL});
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({30'h00000000, busy, pready}, 32'h00000000);
      resetn <= 1'b1;
      rdchk(`CABE_ADDR_PC, 32'h00000000);
      rdchk(`CABE_ADDR_STATUS_FLAGS_REG, 32'h00000000);
      rdchk(`CABE_ADDR_STAT, 32'h00000000);
      test_done;
   end
endmodule
